// >>> logic/cppm_core.v
// four-phase sequencer, fetch/execute pipeline, program counter, data memory map
//
// Contract
// - input clock divided by four into four non-overlapping phases per instruction cycle
// - program counter increments once per cycle, in phase one
// - fetched word is captured from program memory in phase four
// - instruction enters the latch in phase one, executes in phases two to four
// - operand read in phase two, destination written in phase four
// - fetch overlaps execute, one instruction per cycle
// - program counter change discards the prefetched word as a no-operation
// - program counter is 13 bits, 8K words of 14 bits
// - addresses above the implemented 512, 1K or 2K words wrap around
// - reset loads address 0000h, interrupt entry vectors to 0004h
// - status bit 5 selects bank 1 when set, bank 0 when clear
// - first 32 addresses of each bank are special function registers
// - general RAM at 20-7Fh, plus A0-BFh on the largest variant
// - F0h-FFh reach the same locations as 70h-7Fh
// - register file reachable directly and through the indirect pointer
// - unimplemented data memory reads as zero
// - indirect access location has no storage, acts on the pointed location
// - some peripheral registers exist only in bank 1, core ones in both
// - in RC mode the clock output runs at a quarter of the input clock
`timescale 1ns/1ps
`default_nettype none
`include "cppm_consts.vh"

module cppm_core #(
	parameter [1:0] VARIANT = `CPPM_VARIANT_2K
) (
	// clock and reset; clk_sys is the external input clock
	input  wire        clk_sys,
	input  wire        reset,
	// oscillator mode and clock output
	input  wire        rc_osc_mode,
	output reg         instr_rate_clock_out,
	// phase clocks
	output reg         phase_one,
	output reg         phase_two,
	output reg         phase_three,
	output reg         phase_four,
	// program memory
	output reg  [12:0] prog_addr,
	input  wire [13:0] prog_data,
	// execution unit
	output reg  [13:0] instruction_latch,
	output reg  [7:0]  operand_data,
	output reg  [7:0]  core_status,
	input  wire        exec_wr_en,
	input  wire [7:0]  exec_wr_data,
	// interrupt entry
	input  wire        irq_req,
	output reg         irq_ack,
	output reg  [12:0] irq_return_addr,
	// peripheral register port
	output reg  [7:0]  periph_addr,
	output reg         periph_rd,
	output reg         periph_wr,
	output reg  [7:0]  periph_wdata,
	input  wire [7:0]  periph_rdata
);

	localparam [12:0] PC_MASK = (VARIANT == `CPPM_VARIANT_512) ? `CPPM_MASK_512 :
	                            (VARIANT == `CPPM_VARIANT_1K)  ? `CPPM_MASK_1K  :
	                                                             `CPPM_MASK_2K;
	localparam        LARGE   = (VARIANT == `CPPM_VARIANT_2K) ? 1'b1 : 1'b0;

	reg  [1:0]  phase;
	reg  [12:0] pc;
	reg  [13:0] fetch_word;
	reg         flush;
	reg  [7:0]  indirect_pointer;
	reg  [7:0]  pc_high_latch;
	reg         wr_pending;
	reg  [7:0]  wr_data;
	reg  [7:0]  gpr [0:`CPPM_GPR_DEPTH-1];

	reg  [1:0]  next_phase;
	reg  [7:0]  eff_addr;
	reg  [7:0]  rd_value;
	reg         file_op;
	reg         jump_op;
	reg         pc_write;
	reg  [12:0] next_pc;
	reg  [13:0] next_word;
	reg  [7:0]  next_eff_addr;
	reg         exec_flushed;
	wire [2:0]  next_region;
	wire [2:0]  region;
	wire [6:0]  gpr_index;
	wire        bank_select_bit;

	assign bank_select_bit = core_status[`CPPM_BANK_BIT];

	cppm_addr_decode u_decode (
		.full_addr  (eff_addr),
		.large_part (LARGE),
		.region     (region),
		.gpr_index  (gpr_index)
	);

	// decode of the word about to enter the latch, for the phase two operand strobe
	cppm_addr_decode u_decode_next (
		.full_addr  (next_eff_addr),
		.large_part (LARGE),
		.region     (next_region),
		.gpr_index  ()
	);

	// decode of the instruction held in the latch
	always @* begin
		file_op = (instruction_latch[13:12] == `CPPM_OP_FILE);
		jump_op = (instruction_latch[13:11] == `CPPM_OP_JUMP);
		eff_addr = {bank_select_bit, instruction_latch[6:0]};
		if (instruction_latch[6:0] == `CPPM_OFS_INDIRECT)
			eff_addr = indirect_pointer;
		// the latch loads on the same edge, so the old word would address the wrong register
		next_word     = flush ? `CPPM_NOP_WORD : fetch_word;
		next_eff_addr = {bank_select_bit, next_word[6:0]};
		if (next_word[6:0] == `CPPM_OFS_INDIRECT)
			next_eff_addr = indirect_pointer;
	end

	// read data multiplexer over the data memory map
	always @* begin
		case (region)
			`CPPM_RG_PC_LOW:  rd_value = pc[7:0];
			`CPPM_RG_STATUS:  rd_value = core_status;
			`CPPM_RG_POINTER: rd_value = indirect_pointer;
			`CPPM_RG_PC_HIGH: rd_value = pc_high_latch;
			`CPPM_RG_PERIPH:  rd_value = periph_rdata;
			`CPPM_RG_GPR:     rd_value = gpr[gpr_index];
			// pointer at itself and holes both read as zero
			default:          rd_value = `CPPM_BYTE_ZERO;
		endcase
	end

	// program counter change at the end of phase four
	always @* begin
		pc_write = 1'b0;
		next_pc  = pc;
		if (irq_req && !exec_flushed) begin
			pc_write = 1'b1;
			next_pc  = `CPPM_IRQ_VEC;
		end else if (jump_op && !exec_flushed) begin
			pc_write = 1'b1;
			next_pc  = {pc_high_latch[4:3], instruction_latch[10:0]};
		end else if (wr_pending && region == `CPPM_RG_PC_LOW) begin
			pc_write = 1'b1;
			next_pc  = {pc_high_latch[4:0], wr_data};
		end
		next_pc = next_pc & PC_MASK;
	end

	always @* begin
		next_phase = phase + 2'h1;
	end

	// phase sequencer and clock output
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase                <= `CPPM_PH_FOUR;
			phase_one            <= 1'b0;
			phase_two            <= 1'b0;
			phase_three          <= 1'b0;
			phase_four           <= 1'b0;
			instr_rate_clock_out <= 1'b0;
		end else begin
			phase                <= next_phase;
			phase_one            <= (next_phase == `CPPM_PH_ONE);
			phase_two            <= (next_phase == `CPPM_PH_TWO);
			phase_three          <= (next_phase == `CPPM_PH_THREE);
			phase_four           <= (next_phase == `CPPM_PH_FOUR);
			// high in phases three and four in RC mode, low otherwise, one period per instruction cycle
			instr_rate_clock_out <= rc_osc_mode &&
				(next_phase == `CPPM_PH_THREE || next_phase == `CPPM_PH_FOUR);
		end
	end

	// pipeline and program counter
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pc                <= `CPPM_RESET_VEC;
			prog_addr         <= `CPPM_RESET_VEC;
			fetch_word        <= `CPPM_NOP_WORD;
			instruction_latch <= `CPPM_NOP_WORD;
			// nothing valid fetched yet, so the first execute slot is empty
			flush             <= 1'b1;
			exec_flushed      <= 1'b1;
			irq_ack           <= 1'b0;
			irq_return_addr   <= `CPPM_RESET_VEC;
		end else begin
			irq_ack <= 1'b0;
			case (phase)
				`CPPM_PH_ONE: begin
					prog_addr <= pc;
					pc        <= (pc + `CPPM_PC_ONE) & PC_MASK;
					instruction_latch <= flush ? `CPPM_NOP_WORD : fetch_word;
					// marks the whole executing cycle as a discarded slot
					exec_flushed <= flush;
					flush     <= 1'b0;
				end
				`CPPM_PH_FOUR: begin
					fetch_word <= prog_data;
					if (pc_write) begin
						pc    <= next_pc;
						flush <= 1'b1;
					end
					if (irq_req && !exec_flushed) begin
						irq_ack         <= 1'b1;
						irq_return_addr <= pc;
					end
				end
				default: begin
					pc <= pc;
				end
			endcase
		end
	end

	// operand read, destination write and peripheral strobes
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			operand_data     <= `CPPM_BYTE_ZERO;
			core_status      <= `CPPM_STATUS_RESET;
			indirect_pointer <= `CPPM_BYTE_ZERO;
			pc_high_latch    <= `CPPM_BYTE_ZERO;
			wr_pending       <= 1'b0;
			wr_data          <= `CPPM_BYTE_ZERO;
			periph_addr      <= `CPPM_BYTE_ZERO;
			periph_rd        <= 1'b0;
			periph_wr        <= 1'b0;
			periph_wdata     <= `CPPM_BYTE_ZERO;
		end else begin
			periph_rd <= 1'b0;
			periph_wr <= 1'b0;
			case (phase)
				`CPPM_PH_ONE: begin
					// strobe stands through phase two for the operand read
					periph_addr <= next_eff_addr;
					periph_rd   <= (next_word[13:12] == `CPPM_OP_FILE) &&
						next_region == `CPPM_RG_PERIPH;
				end
				`CPPM_PH_TWO: begin
					operand_data <= file_op ? rd_value : `CPPM_BYTE_ZERO;
				end
				`CPPM_PH_THREE: begin
					// result sampled once so phase four sees a stable value
					wr_pending   <= exec_wr_en && file_op &&
						instruction_latch[`CPPM_DEST_BIT];
					wr_data      <= exec_wr_data;
					periph_addr  <= eff_addr;
					periph_wdata <= exec_wr_data;
					periph_wr    <= exec_wr_en && file_op &&
						instruction_latch[`CPPM_DEST_BIT] && region == `CPPM_RG_PERIPH;
				end
				`CPPM_PH_FOUR: begin
					wr_pending <= 1'b0;
					if (wr_pending) begin
						case (region)
							`CPPM_RG_STATUS: core_status <=
								(core_status & ~`CPPM_STATUS_WMASK) |
								(wr_data & `CPPM_STATUS_WMASK);
							`CPPM_RG_POINTER: indirect_pointer <= wr_data;
							`CPPM_RG_PC_HIGH: pc_high_latch <= wr_data;
							default: pc_high_latch <= pc_high_latch;
						endcase
					end
				end
				default: begin
					wr_pending <= wr_pending;
				end
			endcase
		end
	end

	// general purpose register file, written in phase four only
	always @(posedge clk_sys) begin
		if (!reset && phase == `CPPM_PH_FOUR && wr_pending && region == `CPPM_RG_GPR)
			gpr[gpr_index] <= wr_data;
	end

endmodule // cppm_core
`default_nettype wire

// >>> logic/cppm_consts.vh
// constants for the core phase, pipeline and data memory decode block
`ifndef CPPM_CONSTS_VH
`define CPPM_CONSTS_VH

// phase counter codes, one per quarter of an instruction cycle
`define CPPM_PH_ONE        2'h0
`define CPPM_PH_TWO        2'h1
`define CPPM_PH_THREE      2'h2
`define CPPM_PH_FOUR       2'h3

// program counter
`define CPPM_PC_W          13
`define CPPM_RESET_VEC     13'h0000
`define CPPM_IRQ_VEC       13'h0004
`define CPPM_PC_ONE        13'h0001
`define CPPM_MASK_512      13'h01FF
`define CPPM_MASK_1K       13'h03FF
`define CPPM_MASK_2K       13'h07FF
`define CPPM_VARIANT_512   2'h0
`define CPPM_VARIANT_1K    2'h1
`define CPPM_VARIANT_2K    2'h2

// instruction word fields
`define CPPM_NOP_WORD      14'h0000
`define CPPM_OP_FILE       2'h0
`define CPPM_OP_JUMP       3'h5
`define CPPM_DEST_BIT      7

// core register offsets within a bank
`define CPPM_OFS_INDIRECT  7'h00
`define CPPM_OFS_PC_LOW    7'h02
`define CPPM_OFS_STATUS    7'h03
`define CPPM_OFS_POINTER   7'h04
`define CPPM_OFS_PC_HIGH   7'h0A

// core status register
`define CPPM_STATUS_RESET  8'h18
`define CPPM_STATUS_WMASK  8'hE7
`define CPPM_BANK_BIT      5
`define CPPM_BYTE_ZERO     8'h00

// data memory map
`define CPPM_SFR_LAST      7'h1F
`define CPPM_GPR_FIRST     7'h20
`define CPPM_GPR_B1_LAST   7'h3F
`define CPPM_MIRROR_FIRST  7'h70
`define CPPM_GPR_B0_BASE   7'h20
`define CPPM_GPR_B1_ADD    7'h40
`define CPPM_GPR_DEPTH     128

// peripheral register offsets; power and NVM are present in bank 1 only
`define CPPM_PER_TIMER     7'h01
`define CPPM_PER_PORT_A    7'h05
`define CPPM_PER_PORT_B    7'h06
`define CPPM_PER_INT_CTL   7'h0B
`define CPPM_PER_INT_FLAG  7'h0C
`define CPPM_PER_POWER     7'h0E
`define CPPM_PER_NVM       7'h10
`define CPPM_PER_ANALOG    7'h1F

// decode regions
`define CPPM_RG_UNIMP      3'h0
`define CPPM_RG_INDIRECT   3'h1
`define CPPM_RG_PC_LOW     3'h2
`define CPPM_RG_STATUS     3'h3
`define CPPM_RG_POINTER    3'h4
`define CPPM_RG_PC_HIGH    3'h5
`define CPPM_RG_PERIPH     3'h6
`define CPPM_RG_GPR        3'h7

`endif

// >>> logic/cppm_addr_decode.v
// data memory address decode into regions and register file index
`timescale 1ns/1ps
`default_nettype none
`include "cppm_consts.vh"

module cppm_addr_decode (
	// address in
	input  wire [7:0] full_addr,
	input  wire       large_part,
	// decode out
	output reg  [2:0] region,
	output reg  [6:0] gpr_index
);

	reg       bank;
	reg [6:0] low;

	always @* begin
		bank      = full_addr[7];
		low       = full_addr[6:0];
		region    = `CPPM_RG_UNIMP;
		gpr_index = low - `CPPM_GPR_B0_BASE;
		if (low <= `CPPM_SFR_LAST) begin
			// core registers decode the same in both banks
			case (low)
				`CPPM_OFS_INDIRECT: region = `CPPM_RG_INDIRECT;
				`CPPM_OFS_PC_LOW:   region = `CPPM_RG_PC_LOW;
				`CPPM_OFS_STATUS:   region = `CPPM_RG_STATUS;
				`CPPM_OFS_POINTER:  region = `CPPM_RG_POINTER;
				`CPPM_OFS_PC_HIGH:  region = `CPPM_RG_PC_HIGH;
				`CPPM_PER_TIMER, `CPPM_PER_PORT_A, `CPPM_PER_PORT_B,
				`CPPM_PER_INT_CTL, `CPPM_PER_INT_FLAG, `CPPM_PER_ANALOG:
					region = `CPPM_RG_PERIPH;
				`CPPM_PER_POWER, `CPPM_PER_NVM:
					region = bank ? `CPPM_RG_PERIPH : `CPPM_RG_UNIMP;
				default: region = `CPPM_RG_UNIMP;
			endcase
		end else if (!bank) begin
			region = `CPPM_RG_GPR;
		end else if (low >= `CPPM_MIRROR_FIRST) begin
			region = `CPPM_RG_GPR;
		end else if (large_part && low <= `CPPM_GPR_B1_LAST) begin
			region    = `CPPM_RG_GPR;
			gpr_index = low + `CPPM_GPR_B1_ADD;
		end
	end

endmodule // cppm_addr_decode
`default_nettype wire

// >>> verification/cppm_core_sva.sv
// assertions on the core phase sequencer and fetch pipeline
`timescale 1ns/1ps
`default_nettype none
module cppm_core_sva #(
	parameter [1:0] VARIANT = 2'h2
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        reset,
	// phases and clock output
	input wire logic        phase_one,
	input wire logic        phase_two,
	input wire logic        phase_three,
	input wire logic        phase_four,
	input wire logic        instr_rate_clock_out,
	// pipeline and data side
	input wire logic [12:0] prog_addr,
	input wire logic [13:0] instruction_latch,
	input wire logic [7:0]  operand_data,
	input wire logic        irq_ack,
	input wire logic        periph_rd,
	input wire logic        periph_wr
);
	localparam logic [12:0] MASK = (VARIANT == 2'h2) ? 13'h07FF :
		(VARIANT == 2'h1) ? 13'h03FF : 13'h01FF;
	wire logic is_jump = instruction_latch[13:11] == 3'h5;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_rest;
		phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
	endsequence
	a_phase_turn: assert property (phase_one |=> s_rest)
		else $error("phase order broken");
	a_clk_out_low: assert property ((phase_one || phase_two) |-> !instr_rate_clock_out)
		else $error("clock output high in first half");
	a_fetch_hold: assert property (!phase_two |-> $stable(prog_addr))
		else $error("fetch address moved outside phase one end");
	a_latch_hold: assert property (!phase_two |-> $stable(instruction_latch))
		else $error("instruction latch moved outside phase one end");
	a_operand_hold: assert property (!phase_three |-> $stable(operand_data))
		else $error("operand moved outside phase two end");
	a_read_phase: assert property (periph_rd |-> phase_two)
		else $error("peripheral read outside phase two");
	a_write_phase: assert property (periph_wr |-> phase_four)
		else $error("peripheral write outside phase four");
	a_addr_wrap: assert property ((prog_addr & ~MASK) == 13'h0000)
		else $error("fetch address above implemented size");
	a_jump_flush: assert property (phase_two && is_jump |-> ##4 instruction_latch == 14'h0000)
		else $error("prefetched word not discarded");
	a_irq_vector: assert property (irq_ack |=> prog_addr == 13'h0004)
		else $error("interrupt entry did not vector");
endmodule // cppm_core_sva
bind cppm_core cppm_core_sva #(.VARIANT(VARIANT)) u_sva (
	.clk_sys(clk_sys), .reset(reset), .phase_one(phase_one), .phase_two(phase_two),
	.phase_three(phase_three), .phase_four(phase_four),
	.instr_rate_clock_out(instr_rate_clock_out), .prog_addr(prog_addr),
	.instruction_latch(instruction_latch), .operand_data(operand_data),
	.irq_ack(irq_ack), .periph_rd(periph_rd), .periph_wr(periph_wr)
);
`default_nettype wire

// >>> verification/cppm_prog_mem.sv
// program memory model feeding fetch words to the core
`timescale 1ns/1ps
`default_nettype none
module cppm_prog_mem (
	// fetch port
	input  wire logic [12:0] prog_addr,
	output wire logic [13:0] prog_data
);
	// full 8K so a missing wrap fetches a visibly wrong word
	logic [13:0] word [0:8191];
	assign prog_data = word[prog_addr];
endmodule // cppm_prog_mem
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the core phase and pipeline block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        rc_osc_mode = 1'b0;
	logic        exec_wr_en = 1'b0;
	logic [7:0]  exec_wr_data = 8'h00;
	logic        irq_req = 1'b0;
	wire  [12:0] prog_addr;
	wire  [13:0] prog_data;
	wire  [13:0] instruction_latch;
	wire  [7:0]  operand_data;
	wire  [7:0]  core_status;
	wire  [7:0]  periph_addr;
	wire  [7:0]  periph_rdata;
	wire  [3:0]  phases;
	wire         clk_out;
	int          miscompares = 0;
	int          compares = 0;
	// word, write enable, write data, check flag, expected operand
	logic [39:0] rows [0:18] = '{
		40'h00A01A5000, 40'h00F013C000, 40'h08200001A5, 40'h0084120000,
		40'h08000001A5, 40'h0803000118, 40'h0083120118, 40'h087000013C,
		40'h00A015A000, 40'h082000015A, 40'h0803000138, 40'h0841000100,
		40'h080E0001CD, 40'h0083100138, 40'h080E000100, 40'h08200001A5,
		40'h08050001C6, 40'h008A11F000, 40'h0082110000};
	// read data follows the offset so a wrong decode shows
	assign periph_rdata = {1'b0, periph_addr[6:0]} ^ 8'hC3;
	always #50 clk_sys = ~clk_sys;
	cppm_core #(.VARIANT(2'h2)) uut (
		.clk_sys(clk_sys), .reset(reset), .rc_osc_mode(rc_osc_mode),
		.instr_rate_clock_out(clk_out), .phase_one(phases[0]), .phase_two(phases[1]),
		.phase_three(phases[2]), .phase_four(phases[3]), .prog_addr(prog_addr),
		.prog_data(prog_data), .instruction_latch(instruction_latch),
		.operand_data(operand_data), .core_status(core_status),
		.exec_wr_en(exec_wr_en), .exec_wr_data(exec_wr_data), .irq_req(irq_req),
		.irq_ack(), .irq_return_addr(), .periph_addr(periph_addr), .periph_rd(),
		.periph_wr(), .periph_wdata(), .periph_rdata(periph_rdata)
	);
	cppm_prog_mem u_mem (.prog_addr(prog_addr), .prog_data(prog_data));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic sync;
		int n;
		n = 0;
		while (phases[2] !== 1'b1 && n < 8) begin
			@(negedge clk_sys);
			n++;
		end
		if (phases[2] !== 1'b1) begin
			miscompares++;
			wrap_up;
		end
	endtask

	// one instruction cycle, entered at the falling edge in phase three
	task automatic icyc(input logic [12:0] pa, input logic [39:0] r);
		exec_wr_en = r[20];
		exec_wr_data = r[19:12];
		check({3'h0, prog_addr}, {3'h0, pa});
		check({2'h0, instruction_latch}, r[39:24]);
		if (r[8])
			check({8'h00, operand_data}, {8'h00, r[7:0]});
		@(negedge clk_sys);
		exec_wr_en = 1'b0;
		check({15'h0, clk_out}, {15'h0, rc_osc_mode});
		repeat (3) @(negedge clk_sys);
	endtask

	initial begin
		for (int i = 0; i < 8192; i++)
			u_mem.word[i] = (i < 19) ? rows[i][37:24] : 14'h0000;
		u_mem.word[13'h0710] = 14'h2805;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		sync;
		icyc(13'h0000, 40'h0);
		for (int i = 0; i < 19; i++)
			icyc(13'(i + 1), rows[i]);
		// high latch 1F puts the low byte jump above 2K
		icyc(13'h0710, 40'h0);
		icyc(13'h0711, 40'h2805000000);
		rc_osc_mode = 1'b1;
		// request during a flushed cycle must wait
		irq_req = 1'b1;
		icyc(13'h0005, 40'h0);
		icyc(13'h0006, rows[5]);
		irq_req = 1'b0;
		icyc(13'h0004, 40'h0);
		icyc(13'h0005, rows[4]);
		reset = 1'b1;
		@(negedge clk_sys);
		check({4'h0, core_status, phases}, 16'h0180);
		check({2'h0, instruction_latch | {1'b0, prog_addr}}, 16'h0000);
		reset = 1'b0;
		sync;
		icyc(13'h0000, 40'h0);
		icyc(13'h0001, rows[0]);
		wrap_up;
	end
endmodule // tb
`default_nettype wire
